/* rtl/pfc_pkg.sv */
// Purpose: shared constants and types for the pack protection FET control
// Assumes: 125 MHz system clock, AHB-Lite word registers
// Notes: register offsets are byte addresses of aligned words
package pfc_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_FRONT_END_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LATCH_STATUS = 8'h04;
   localparam logic [7:0] ADDR_OVERCUR_CTRL = 8'h08; // then the three shorts
   localparam logic [7:0] ADDR_PROT_SCALE = 8'h18;
   localparam logic [7:0] ADDR_CELL_BALANCE = 8'h1c;
   localparam logic [7:0] ADDR_SLEEP_INTERVAL = 8'h20;
   localparam logic [7:0] ADDR_CC_COUNT = 8'h24;
   localparam logic [7:0] ADDR_CC_TIMER = 8'h28;
   localparam logic [7:0] ADDR_BLOCK_STATE = 8'h2c;
   // ==========================================================
   // field positions
   localparam int CTRL_CHARGE_EN_BIT = 0;
   localparam int CTRL_DISCH_EN_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam int ST_OVERCUR = 0;
   localparam int ST_CHARGE_SHORT = 1;
   localparam int ST_DIS_SHORT1 = 2;
   localparam int ST_DIS_SHORT2 = 3;
   localparam int ST_OSC = 4;
   localparam int NUM_DET = 4;
   // ==========================================================
   // reset values
   localparam logic [3:0] CTRL_RESET = 4'h3;
   localparam logic [7:0] THRESH_RESET = 8'h40;
   localparam logic [7:0] DELAY_RESET = 8'h10;
   localparam logic [3:0] SCALE_RESET = 4'h0;
   localparam logic [7:0] SLEEP_RESET = 8'h04;
   // ==========================================================
   // timing
   localparam longint CLOCK_HZ = 125_000_000;
   localparam int UPDATE_PERIOD_MS = 250;
   localparam int UPDATE_CYCLES_DEF = int'(CLOCK_HZ / 1000 * UPDATE_PERIOD_MS);
   localparam int STAB_TIME_US = 2000;
   localparam int STAB_CYCLES_DEF = int'(CLOCK_HZ / 1_000_000 * STAB_TIME_US);
   localparam longint SLOW_OSC_HZ = 262_144;
   localparam longint FAST_OSC_HZ = SLOW_OSC_HZ * 64;
   localparam int SLOW_PERIOD_CYCLES = int'(CLOCK_HZ / SLOW_OSC_HZ);
   localparam logic [10:0] OSC_FAIL_CYCLES = 11'(2 * SLOW_PERIOD_CYCLES);
   localparam logic [31:0] NCO_STEP = 32'((FAST_OSC_HZ << 32) / CLOCK_HZ);
   localparam int DELAY_UNIT_NS = 1000;
   localparam int DELAY_UNIT_CYCLES =
      int'((DELAY_UNIT_NS * CLOCK_HZ + 999_999_999) / 1_000_000_000);
   localparam int THRESH_UNIT_UV = 1000;
   localparam logic signed [17:0] SENSE_FS_UV = 18'h1_86a0; // 100 mV
   localparam int CC_RATE_PVH = 650; // charge per count, in pV h
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_SHUTDOWN = 2'b10
   } pfc_mode_e;
   typedef enum logic [1:0] {
      ST_STABILIZE = 2'b00,
      ST_TRIM = 2'b01,
      ST_ACTIVE = 2'b10
   } pfc_state_e;
   typedef struct packed {
      logic [7:0] delay;
      logic [7:0] threshold;
   } pfc_prot_cfg_s;
endpackage

/* rtl/pfc_fault_det.sv */
// Purpose: one current fault detector with persistence delay
// Assumes: over is a synchronous level
// Notes: any drop of the condition restarts the delay
`timescale 1ns/1ns
`default_nettype none
module pfc_fault_det #(
   parameter int unsigned CW = 20
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic arm,
   input wire logic over,
   input wire logic [CW-1:0] delay,
   output var logic trip
);
   // ==========================================================
   // persistence counter
   logic [CW-1:0] cnt_q;
   wire held = cnt_q >= delay;

   // filter: a glitch shorter than delay + 1 cycles never reaches the gate drives
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
         trip <= 1'b0;
      end else if (!arm || !over) begin
         cnt_q <= '0;
         trip <= 1'b0;
      end else begin
         if (!held) cnt_q <= cnt_q + 1'b1;
         trip <= held;
      end
   end
endmodule // pfc_fault_det
`default_nettype wire

/* rtl/pfc_top.sv */
// Purpose: pack protection FET control, scheduling and charge counting
// Assumes: AHB-Lite slave, sense samples in microvolts, sync inputs
// Notes: reads take one wait state, writes none
// What this block does
// - any hardware safety fault turns both gate drives off.
// - software clearing both gate enables turns both gate drives off.
// - slow oscillator far too slow sets the latched failure bit.
// - fast clock derived from slow rate, halved to 50% output.
// - overcurrent threshold and delay come from its own control register.
// - shared scale register shifts all current thresholds and delays.
// - overcurrent must persist through its delay before gates go off.
// - overcurrent latches status bit until cleared and condition gone.
// - charge short threshold and delay come from its own register.
// - charge short is blanked by its delay before gates go off.
// - charge short latches status bit until cleared and fault gone.
// - two discharge short detectors, each with own register and delay.
// - each discharge short latches its own bit until cleared and gone.
// - two balancing bits drive the two cell bypass switches.
// - normal mode runs an update every 250 ms, low power between.
// - sleep updates at configurable interval; shutdown disables all but the slow oscillator monitor.
// - integrator takes +-100 mV, positive means charge current.
// - free running timer and counter accumulate charge counts.
// - after reset hold a stabilisation time, then load trim.
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pfc_top import pfc_pkg::*; #(
   parameter int unsigned UPDATE_CYCLES = UPDATE_CYCLES_DEF,
   parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output var logic [31:0] hrdata,
   output var logic hreadyout,
   output var logic hresp,
   input wire logic signed [17:0] sense_microvolts,
   input wire logic sense_valid,
   input wire logic safety_overvoltage_fault,
   input wire logic slow_oscillator,
   output var logic charge_fet_gate,
   output var logic discharge_fet_gate,
   output var logic balance_cell_one,
   output var logic balance_cell_two,
   output var logic fast_clock_out,
   output var logic update_pulse,
   output var logic low_power,
   output var logic trim_load
);
   // ==========================================================
   // state
   logic [3:0] ctrl_q;
   logic [4:0] status_q;
   pfc_prot_cfg_s prot_q [NUM_DET];
   logic [3:0] scale_q;
   logic [1:0] bal_q;
   logic [7:0] sleep_q, sleep_cnt_q;
   logic signed [31:0] cc_q;
   logic [31:0] cc_timer_q, stab_cnt_q, sched_cnt_q, nco_q;
   pfc_state_e state_q;
   logic osc_prev_q;
   logic [10:0] osc_cnt_q;
   logic ap_wr_q, rd_pend_q;
   logic [7:0] ap_addr_q;
   logic [NUM_DET-1:0] trip_v, over_v;

   // ==========================================================
   // bus decode
   wire accept = hsel && htrans[1] && hready;
   wire wr_ctrl = ap_wr_q && ap_addr_q == ADDR_FRONT_END_CTRL;
   wire wr_stat = ap_wr_q && ap_addr_q == ADDR_LATCH_STATUS;
   wire wr_scale = ap_wr_q && ap_addr_q == ADDR_PROT_SCALE;
   wire wr_bal = ap_wr_q && ap_addr_q == ADDR_CELL_BALANCE;
   wire wr_sleep = ap_wr_q && ap_addr_q == ADDR_SLEEP_INTERVAL;
   wire pfc_mode_e mode = pfc_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
   wire active = state_q == ST_ACTIVE;
   wire shutdown = mode == MODE_SHUTDOWN;
   wire run = active && !shutdown;

   // read selection; unmapped words read as zero
   wire [31:0] rd_data =
      ap_addr_q == ADDR_FRONT_END_CTRL ? {28'h000_0000, ctrl_q} :
      ap_addr_q == ADDR_LATCH_STATUS ? {27'h000_0000, status_q} :
      ap_addr_q == ADDR_OVERCUR_CTRL ? {16'h0000, prot_q[0]} :
      ap_addr_q == ADDR_OVERCUR_CTRL + 8'h04 ? {16'h0000, prot_q[1]} :
      ap_addr_q == ADDR_OVERCUR_CTRL + 8'h08 ? {16'h0000, prot_q[2]} :
      ap_addr_q == ADDR_OVERCUR_CTRL + 8'h0c ? {16'h0000, prot_q[3]} :
      ap_addr_q == ADDR_PROT_SCALE ? {28'h000_0000, scale_q} :
      ap_addr_q == ADDR_CELL_BALANCE ? {30'h0000_0000, bal_q} :
      ap_addr_q == ADDR_SLEEP_INTERVAL ? {24'h00_0000, sleep_q} :
      ap_addr_q == ADDR_CC_COUNT ? cc_q :
      ap_addr_q == ADDR_CC_TIMER ? cc_timer_q :
      ap_addr_q == ADDR_BLOCK_STATE ? {24'h00_0000, charge_fet_gate,
         discharge_fet_gate, fast_clock_out, low_power, shutdown,
         status_q[ST_OSC], state_q} : 32'h0000_0000;

   // address phase capture; a read holds hready low for one cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ap_wr_q <= 1'b0;
         rd_pend_q <= 1'b0;
         ap_addr_q <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         ap_wr_q <= accept && hwrite;
         rd_pend_q <= accept && !hwrite;
         if (accept) ap_addr_q <= haddr[7:0];
         hreadyout <= !(accept && !hwrite);
         hresp <= 1'b0;
         if (rd_pend_q) hrdata <= rd_data;
      end
   end

   // ==========================================================
   // software registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_q <= CTRL_RESET;
         scale_q <= SCALE_RESET;
         bal_q <= 2'b00;
         sleep_q <= SLEEP_RESET;
      end else begin
         if (wr_ctrl) ctrl_q <= hwdata[3:0];
         if (wr_scale) scale_q <= hwdata[3:0];
         if (wr_bal) bal_q <= hwdata[1:0];
         if (wr_sleep) sleep_q <= hwdata[7:0];
      end
   end

   // ==========================================================
   // current detectors
   // clamp to the integrator's input range
   wire signed [17:0] sense_cl =
      sense_microvolts > SENSE_FS_UV ? SENSE_FS_UV :
      sense_microvolts < -SENSE_FS_UV ? -SENSE_FS_UV : sense_microvolts;
   wire [17:0] dis_mag = sense_cl < 0 ? 18'(-sense_cl) : 18'h0_0000;
   wire [17:0] charge_mag = sense_cl > 0 ? 18'(sense_cl) : 18'h0_0000;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DET; gi++) begin : g_det
         wire [7:0] off = ADDR_OVERCUR_CTRL + 8'(4 * gi);
         // lower resistance shunts need lower thresholds and delays
         wire [17:0] thr = 18'((32'(prot_q[gi].threshold) * THRESH_UNIT_UV)
            >> scale_q[1:0]);
         wire [19:0] dly = 20'((32'(prot_q[gi].delay) * DELAY_UNIT_CYCLES)
            >> scale_q[3:2]);
         // index one looks at charge direction, the rest at discharge
         assign over_v[gi] = (gi == ST_CHARGE_SHORT) ?
            charge_mag > thr : dis_mag > thr;
         always_ff @(posedge clock or posedge reset) begin
            if (reset) prot_q[gi] <= {DELAY_RESET, THRESH_RESET};
            else if (ap_wr_q && ap_addr_q == off) prot_q[gi] <= hwdata[15:0];
         end
         pfc_fault_det #(.CW(20)) u_det (
            .clock(clock),
            .reset(reset),
            .arm(run),
            .over(over_v[gi]),
            .delay(dly),
            .trip(trip_v[gi])
         );
      end
   endgenerate

   // ==========================================================
   // slow oscillator monitor
   wire osc_rise = slow_oscillator && !osc_prev_q;
   wire osc_timeout = osc_cnt_q == OSC_FAIL_CYCLES;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         osc_prev_q <= 1'b0;
         osc_cnt_q <= 11'h000;
      end else begin
         osc_prev_q <= slow_oscillator;
         if (osc_rise || !active) osc_cnt_q <= 11'h000;
         else if (!osc_timeout) osc_cnt_q <= osc_cnt_q + 11'h001;
      end
   end

   // ==========================================================
   // latched status; a set in the clearing cycle wins
   wire [4:0] set_v = {osc_timeout, trip_v};
   wire [4:0] cond_v = {osc_timeout, over_v};
   wire [4:0] clr_v = wr_stat ? hwdata[4:0] & ~cond_v : 5'h00;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) status_q <= 5'h00;
      else status_q <= set_v | (status_q & ~clr_v);
   end

   // ==========================================================
   // gate drives and balancing
   wire fault_now = |trip_v || safety_overvoltage_fault;
   wire gate_ok = run && !fault_now && !(|status_q[3:0]);
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         charge_fet_gate <= 1'b0;
         discharge_fet_gate <= 1'b0;
         balance_cell_one <= 1'b0;
         balance_cell_two <= 1'b0;
      end else begin
         charge_fet_gate <= gate_ok && ctrl_q[CTRL_CHARGE_EN_BIT];
         discharge_fet_gate <= gate_ok && ctrl_q[CTRL_DISCH_EN_BIT];
         balance_cell_one <= run && bal_q[0];
         balance_cell_two <= run && bal_q[1];
      end
   end

   // ==========================================================
   // power-on stabilisation and trim load
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= ST_STABILIZE;
         stab_cnt_q <= 32'h0000_0000;
         trim_load <= 1'b0;
      end else begin
         trim_load <= state_q == ST_TRIM;
         case (state_q)
            ST_STABILIZE: begin
               stab_cnt_q <= stab_cnt_q + 32'h0000_0001;
               if (stab_cnt_q == 32'(STAB_CYCLES - 1)) state_q <= ST_TRIM;
            end
            ST_TRIM: state_q <= ST_ACTIVE;
            ST_ACTIVE: state_q <= ST_ACTIVE;
            default: state_q <= ST_STABILIZE;
         endcase
      end
   end

   // ==========================================================
   // update scheduler
   wire sched_wrap = sched_cnt_q == 32'(UPDATE_CYCLES - 1);
   wire sleep_due = sleep_cnt_q + 8'h01 >= sleep_q; // zero acts as one
   wire upd_now = run && sched_wrap && (mode != MODE_SLEEP || sleep_due);
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sched_cnt_q <= 32'h0000_0000;
         sleep_cnt_q <= 8'h00;
         update_pulse <= 1'b0;
         low_power <= 1'b1;
      end else begin
         if (!run || sched_wrap) sched_cnt_q <= 32'h0000_0000;
         else sched_cnt_q <= sched_cnt_q + 32'h0000_0001;
         if (!run || mode != MODE_SLEEP || upd_now) sleep_cnt_q <= 8'h00;
         else if (sched_wrap) sleep_cnt_q <= sleep_cnt_q + 8'h01;
         update_pulse <= upd_now;
         low_power <= !upd_now;
      end
   end

   // ==========================================================
   // fast clock synthesis; follows the slow rate, stops on failure
   wire [32:0] nco_sum = {1'b0, nco_q} + {1'b0, NCO_STEP};
   wire fast_run = run && !status_q[ST_OSC];
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         nco_q <= 32'h0000_0000;
         fast_clock_out <= 1'b0;
      end else if (fast_run) begin
         nco_q <= nco_sum[31:0];
         if (nco_sum[32]) fast_clock_out <= !fast_clock_out;
      end
   end

   // ==========================================================
   // charge counting integrator, positive is charge
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cc_q <= 32'sh0000_0000;
         cc_timer_q <= 32'h0000_0000;
      end else if (run) begin
         cc_timer_q <= cc_timer_q + 32'h0000_0001;
         if (sense_valid) cc_q <= cc_q + 32'(sense_cl);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [31:0] gap_q;
   logic norm_seen_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gap_q <= 32'h0000_0000;
         norm_seen_q <= 1'b0;
      end else begin
         gap_q <= update_pulse ? 32'h0000_0000 : gap_q + 32'h0000_0001;
         if (mode != MODE_NORMAL || !run) norm_seen_q <= 1'b0;
         else if (update_pulse) norm_seen_q <= 1'b1;
      end
   end
   sequence s_trim_step;
      state_q == ST_TRIM ##1 state_q == ST_ACTIVE && trim_load;
   endsequence
   sequence s_gates_off;
      !charge_fet_gate && !discharge_fet_gate;
   endsequence

   safety_gate_off_a: assert property (fault_now |=> s_gates_off)
      else $error("gate on after safety fault");
   soft_gate_off_a: assert property (
      !ctrl_q[CTRL_CHARGE_EN_BIT] && !ctrl_q[CTRL_DISCH_EN_BIT] |=> s_gates_off)
      else $error("gate on with enables clear");
   osc_fail_a: assert property (osc_timeout |=> status_q[ST_OSC])
      else $error("slow oscillator failure not latched");
   fast_toggle_a: assert property (
      fast_clock_out != $past(fast_clock_out) |->
      $past(nco_sum[32] && fast_run))
      else $error("fast clock toggled without carry");
   // trip is registered, so it pairs with the condition one cycle back
   trip_needs_over_a: assert property (
      |trip_v |-> (trip_v & ~$past(over_v)) == 4'h0)
      else $error("detector tripped without condition");
   latch_set_a: assert property (
      |trip_v |=> (status_q[3:0] & $past(trip_v)) == $past(trip_v))
      else $error("fault trip not latched");
   latch_hold_a: assert property (
      (($past(status_q[3:0]) & ~status_q[3:0]) & $past(over_v)) == 4'h0)
      else $error("status cleared while fault present");
   sticky_gate_a: assert property (|status_q[3:0] |=> s_gates_off)
      else $error("gate on while fault latched");
   balance_a: assert property (
      run ##1 run |-> balance_cell_one == $past(bal_q[0]) &&
      balance_cell_two == $past(bal_q[1]))
      else $error("balance switch mismatch");
   normal_period_a: assert property (
      update_pulse && norm_seen_q && mode == MODE_NORMAL |->
      gap_q == 32'(UPDATE_CYCLES - 1))
      else $error("normal update period wrong");
   shutdown_a: assert property (
      shutdown ##1 shutdown |->
      ((!update_pulse && !balance_cell_one && !balance_cell_two)
      and s_gates_off))
      else $error("activity in shutdown");
   cc_sign_a: assert property (
      run && sense_valid |=> cc_q - $past(cc_q) == 32'($past(sense_cl)))
      else $error("charge count step wrong");
   trim_after_a: assert property (
      state_q == ST_TRIM |-> s_trim_step)
      else $error("trim load out of order");
   no_early_trim_a: assert property (
      state_q == ST_STABILIZE |-> !trim_load)
      else $error("trim before stabilisation");
endmodule // pfc_top
`default_nettype wire

/* dv/pfc_fet_model.sv */
// Purpose: back-to-back charge and discharge fet pair beside the block
// Assumes: gate high means the fet is driven on
// Notes: a released gate is pulled to its source, so the path opens at once
`timescale 1ns/1ns
`default_nettype none
module pfc_fet_model (
   input wire logic charge_fet_gate,
   input wire logic discharge_fet_gate,
   output var logic charge_path_on,
   output var logic discharge_path_on
);
   // ==========================================================
   // conduction: no memory, an undriven gate never conducts
   always_comb begin
      charge_path_on = (charge_fet_gate === 1'b1);
      discharge_path_on = (discharge_fet_gate === 1'b1);
   end
endmodule // pfc_fet_model
`default_nettype wire

/* dv/test_pfc_top.sv */
// Purpose: self-checking bench for the pack protection fet control
// Assumes: short stabilise and update counts for simulation
// Notes: bus tasks wait on hreadyout, bounded by the cycle ceiling
`timescale 1ns/1ns
`default_nettype none
module test_pfc_top;
   import pfc_pkg::*;
   localparam int UPD = 20;
   localparam int STAB = 5;
   logic clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q, cc0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic hreadyout, hresp, sense_valid = 1'b0, ov_fault = 1'b0, slow = 1'b0;
   logic signed [17:0] sense = '0;
   logic cgate, dgate, bal1, bal2, fclk, upd, lowp, trim, cpath, dpath;
   logic osc_run = 1'b1, fprev = 1'b0;
   int errors = 0, num_checks = 0, cycles = 0, n, k;
   pfc_top #(.UPDATE_CYCLES(UPD), .STAB_CYCLES(STAB)) dut_u (.clock(clock),
      .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sense_microvolts(sense), .sense_valid(sense_valid),
      .safety_overvoltage_fault(ov_fault), .slow_oscillator(slow),
      .charge_fet_gate(cgate), .discharge_fet_gate(dgate),
      .balance_cell_one(bal1), .balance_cell_two(bal2),
      .fast_clock_out(fclk), .update_pulse(upd), .low_power(lowp),
      .trim_load(trim));
   pfc_fet_model fet_u (.charge_fet_gate(cgate), .discharge_fet_gate(dgate),
      .charge_path_on(cpath), .discharge_path_on(dpath));
   // ==========================================================
   // clock, slow oscillator and the hang ceiling
   always #4 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (osc_run && cycles % 238 == 0) slow <= ~slow;
      if (cycles == 30000) begin
         errors++;
         test_done();
      end
   end
   // ==========================================================
   // bus and compare tasks; called just after a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, q);
   endtask
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000, q);
      check(what, exp, q);
      check("okay response", 32'h0000_0000, hresp);
   endtask
   task automatic wait_n(input int c);
      repeat (c) @(posedge clock);
   endtask
   task automatic gates(input string what, input logic v);
      wait_n(4);
      check(what, {30'h0, v, v}, {30'h0, cpath, dpath});
   endtask
   // period between update pulses, measured on the second interval
   task automatic gap(output int p);
      repeat (2) begin
         k = 0;
         while (upd !== 1'b1 && k < 1000) begin
            @(posedge clock);
            k++;
         end
         p = 0;
         do begin
            @(posedge clock);
            p++;
         end while (upd !== 1'b1 && p < 1000);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      wait_n(6);
      reset <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (trim !== 1'b1 && n < 100);
      check("trim edge", STAB + 2, n);
      rdchk("ctrl reset", ADDR_FRONT_END_CTRL, {28'h0, CTRL_RESET});
      rdchk("overcurrent reset", ADDR_OVERCUR_CTRL,
         {16'h0, DELAY_RESET, THRESH_RESET});
      rdchk("unmapped", 8'h3c, 32'h0000_0000);
      $display("test reset finished");
      gates("gates on", 1'b1);
      wr(ADDR_FRONT_END_CTRL, 32'h0000_0000);
      gates("sw off", 1'b0);
      wr(ADDR_FRONT_END_CTRL, 32'h0000_0003);
      gates("sw on", 1'b1);
      ov_fault <= 1'b1;
      gates("ov off", 1'b0);
      ov_fault <= 1'b0;
      gates("ov gone", 1'b1);
      $display("test gates finished");
      for (int b = 0; b < 4; b++) begin
         wr(ADDR_CELL_BALANCE, b);
         wait_n(2);
         check("balance", b, {bal2, bal1});
      end
      n = 0;
      fprev = fclk;
      // count rising edges of the fast clock over 1000 cycles
      for (int c = 0; c < 1000; c++) begin
         @(posedge clock);
         if (fclk === 1'b1 && fprev === 1'b0) n++;
         fprev = fclk;
      end
      check("fast clock", 1, (n >= 66 && n <= 68));
      xfer(1'b0, ADDR_CC_COUNT, 32'h0, cc0);
      sense_valid <= 1'b1;
      sense <= 18'sd120000;
      wait_n(2);
      sense <= -18'sd30000;
      wait_n(5);
      sense_valid <= 1'b0;
      sense <= '0;
      wait_n(3);
      rdchk("count", ADDR_CC_COUNT, cc0 + 32'd50000);
      $display("test analog finished");
      gap(n);
      check("normal period", UPD, n);
      check("low power", 0, lowp);
      wr(ADDR_SLEEP_INTERVAL, 32'h0000_0002);
      wr(ADDR_FRONT_END_CTRL, 32'h0000_0007);
      gap(n);
      check("sleep period", 2 * UPD, n);
      wr(ADDR_FRONT_END_CTRL, 32'h0000_000b);
      gap(n);
      check("shutdown pulses", 1000, n);
      check("shutdown low power", 1, lowp);
      gates("shutdown gates", 1'b0);
      wr(ADDR_FRONT_END_CTRL, 32'h0000_0003);
      $display("test schedule finished");
      for (int i = 0; i < NUM_DET; i++) begin
         for (int j = 0; j < NUM_DET; j++)
            wr(ADDR_OVERCUR_CTRL + 8'(4 * j),
               (i == j) ? 32'h0000_0210 : 32'h0000_02ff);
         sense <= (i == ST_CHARGE_SHORT) ? 18'sd50000 : -18'sd50000;
         gates("before delay", 1'b1);
         wait_n(400);
         gates("tripped", 1'b0);
         wr(ADDR_LATCH_STATUS, 32'h1 << i);
         rdchk("held", ADDR_LATCH_STATUS, 32'h1 << i);
         sense <= '0;
         gates("latched off", 1'b0);
         wr(ADDR_LATCH_STATUS, 32'h1 << i);
         rdchk("cleared", ADDR_LATCH_STATUS, 32'h0);
         gates("back on", 1'b1);
      end
      // writes to an unmapped word are dropped
      wr(8'h3c, 32'hffff_ffff);
      rdchk("unmapped write", 8'h3c, 32'h0000_0000);
      $display("test detectors finished");
      osc_run <= 1'b0;
      wait_n(1100);
      rdchk("osc fail", ADDR_LATCH_STATUS, 32'h1 << ST_OSC);
      $display("test oscillator finished");
      test_done();
   end
endmodule // test_pfc_top
`default_nettype wire
